// *** verilog/prag_pkg.sv ***
// Package of constants and types for the paged read address generator
package prag_pkg;
	localparam int          PAGE_W         = 10;          // Read page register width
	localparam int          EA_W           = 16;          // Effective address width
	localparam int          RADDR_W        = 24;          // Extended read address width
	localparam int          WINDOW_BIT     = 15;          // Effective address window bit
	localparam int          PS_BIT         = 9;           // Page bit selecting program space
	localparam logic [9:0]  PAGE_RESET     = 10'h001;     // Page after reset
	localparam logic [9:0]  PAGE_ZERO      = 10'h000;     // Illegal paged page
	localparam logic [9:0]  PAGE_PS_FIRST  = 10'h200;     // First program space page
	localparam logic [9:0]  PAGE_LAST      = 10'h3ff;     // Last page
	localparam logic [9:0]  PAGE_FIRST     = 10'h001;     // First data page
	localparam int          WINDOW_BYTES   = 32768;       // Bytes per page window
	localparam int          ADJ_LATENCY    = 1;           // Cycles from request to page update

	// Addressing mode of the current effective address calculation
	typedef enum logic [2:0] {
		PRAG_MODE_INDIRECT,
		PRAG_MODE_PRE_MOD,
		PRAG_MODE_POST_MOD,
		PRAG_MODE_REG_OFFSET,
		PRAG_MODE_MODULO,
		PRAG_MODE_BIT_REV
	} prag_mode_type;

	// Kind of boundary event seen on the raw calculation
	typedef enum logic [1:0] {
		PRAG_EV_NONE,
		PRAG_EV_OVERFLOW,
		PRAG_EV_UNDERFLOW
	} prag_event_type;
endpackage : prag_pkg

// *** verilog/prag_boundary.sv ***
// Boundary crossing classifier for the paged read address generator
module prag_boundary (
	input  wire logic                   base_in_window, // Address before modification had bit 15 set
	input  wire logic                   raw_bit15,      // Bit 15 of the raw modified address
	input  wire logic                   dir_down,       // Modification direction is decrement
	output prag_pkg::prag_event_type    event_kind      // Detected crossing
);
	// Crossing only when leaving a paged window by clearing bit 15
	wire crossed = base_in_window & ~raw_bit15; // RULE5 RULE6

	// Direction picks overflow or underflow
	assign event_kind = !crossed ? prag_pkg::PRAG_EV_NONE :
		(dir_down ? prag_pkg::PRAG_EV_UNDERFLOW : prag_pkg::PRAG_EV_OVERFLOW);
endmodule : prag_boundary

// *** verilog/prag_gen.sv ***
// Paged read address generator: page register, window mapping and page stepping
// Operation
// RULE1 - Page bits 8..0 above address bits 14..0
// RULE2 - Page 0x200 and above maps program space
// RULE3 - Program space is read only via paging
// RULE4 - 32 Kbyte windows spanning 8 Mbytes (code: 9 page bits, 512 windows, 16 Mbytes)
// RULE5 - Raw calculation clearing bit 15 marks crossing
// RULE6 - Crossing needs prior address in paged window
// RULE7 - Page steps only for pre/post modified indirect
// RULE8 - Overflow increments page, bit 15 set
// RULE9 - Underflow decrements page, bit 15 set
// RULE10 - Offset, modulo, bit-reverse wrap within page
// RULE11 - Page register resets to 0x001
// RULE12 - Paged access with page 0x000 traps
// RULE13 - Addresses below 0x8000 are accessed directly
// RULE14 - Boundary pages 0x3FF, 0x001, 0x200 stay put
module prag_gen #(
	parameter int PAGE_WIDTH = 10,   // Read page register width
	parameter int EA_WIDTH   = 16    // Effective address width
) (
	input  wire logic                    clk,            // Core clock
	input  wire logic                    reset_n,        // Synchronous reset, active low
	input  wire logic                    ea_valid,       // Effective address calculation valid
	input  wire logic [EA_WIDTH-1:0]     ea_base,        // Address before modification
	input  wire logic [EA_WIDTH-1:0]     ea_raw,         // Raw modified effective address
	input  wire logic                    ea_dir_down,    // Modification decrements
	input  wire prag_pkg::prag_mode_type ea_mode,        // Addressing mode of calculation
	input  wire logic                    access_read,    // Access is a read
	input  wire logic                    access_write,   // Access is a write
	input  wire logic                    page_wr,        // Software write to page register
	input  wire logic [PAGE_WIDTH-1:0]   page_wdata,     // Page value written
	output logic [PAGE_WIDTH-1:0]        read_page_register, // Current read page
	output logic [EA_WIDTH-1:0]          effective_address,  // Corrected effective address
	output logic [23:0]                  read_addr,      // Extended read address
	output logic                         read_addr_valid, // Read address is valid
	output logic                         program_space_window, // Read maps to program space
	output logic                         extended_data_space,  // Access is paged
	output logic                         base_direct,    // Access goes to base space
	output logic                         ps_write_block, // Write into program space refused
	output logic                         addr_error_trap // Paged access with page zero, pulse
);
	// Elaboration check: the logic is built for the documented widths
	if (PAGE_WIDTH != prag_pkg::PAGE_W || EA_WIDTH != prag_pkg::EA_W) begin : g_width_check
		$error("prag_gen supports only 10-bit pages and 16-bit addresses");
	end

	logic [PAGE_WIDTH-1:0] page_reg;        // Read page register
	logic [PAGE_WIDTH-1:0] page_next;       // Next page value
	logic [EA_WIDTH-1:0]   ea_reg;          // Registered corrected address
	logic [EA_WIDTH-1:0]   ea_next;         // Corrected address
	logic [23:0]           raddr_reg;       // Registered read address
	logic                  rvalid_reg;      // Registered valid
	logic                  ps_reg;          // Registered program space flag
	logic                  paged_reg;       // Registered paged flag
	logic                  direct_reg;      // Registered base flag
	logic                  wblock_reg;      // Registered write refusal
	logic                  trap_reg;        // Registered trap pulse

	prag_pkg::prag_event_type ev;           // Boundary event

	// Boundary classifier
	prag_boundary u_boundary (
		.base_in_window (ea_base[prag_pkg::WINDOW_BIT]),
		.raw_bit15      (ea_raw[prag_pkg::WINDOW_BIT]),
		.dir_down       (ea_dir_down),
		.event_kind     (ev)
	);

	// Mode decode
	wire stepping_mode = (ea_mode == prag_pkg::PRAG_MODE_PRE_MOD) ||
		(ea_mode == prag_pkg::PRAG_MODE_POST_MOD);                  // RULE7
	wire wrap_mode     = (ea_mode == prag_pkg::PRAG_MODE_REG_OFFSET) ||
		(ea_mode == prag_pkg::PRAG_MODE_MODULO) ||
		(ea_mode == prag_pkg::PRAG_MODE_BIT_REV);                   // RULE10
	wire is_ovf        = ev == prag_pkg::PRAG_EV_OVERFLOW;          // RULE5
	wire is_unf        = ev == prag_pkg::PRAG_EV_UNDERFLOW;

	// Boundary exceptions: page held and bit 15 left clear
	// Keeps the page from wrapping into page zero or stepping down from 0x200 out of program space
	wire exc_case = (is_ovf && page_reg == prag_pkg::PAGE_LAST) ||
		(is_unf && page_reg == prag_pkg::PAGE_FIRST) ||
		(is_unf && page_reg == prag_pkg::PAGE_PS_FIRST);           // RULE14

	wire do_step  = ea_valid && stepping_mode && (is_ovf || is_unf) && !exc_case;
	wire do_wrap  = ea_valid && wrap_mode && (is_ovf || is_unf);
	wire force_15 = do_step || do_wrap;                             // RULE8 RULE9 RULE10

	// Page stepping
	wire [PAGE_WIDTH-1:0] page_inc = page_reg + 10'h001;            // RULE8
	wire [PAGE_WIDTH-1:0] page_dec = page_reg - 10'h001;            // RULE9
	wire [PAGE_WIDTH-1:0] page_step = is_ovf ? page_inc : page_dec;

	// Next page: a step wins over a software write in the same cycle
	// Software must not rely on a write landing during a crossing
	assign page_next = do_step ? page_step : (page_wr ? page_wdata : page_reg);

	// Corrected address: bit 15 forced back on a handled crossing
	// Exceptions leave bit 15 clear so the access drops to base space
	assign ea_next = force_15 ? (ea_raw | 16'h8000) : ea_raw;

	// Window decode on the corrected address and the page after stepping
	wire in_window = ea_next[prag_pkg::WINDOW_BIT];                 // RULE13
	wire paged     = ea_valid && in_window;
	wire ps_page   = page_next[prag_pkg::PS_BIT];                   // RULE2
	wire page_bad  = page_next == prag_pkg::PAGE_ZERO;              // RULE12

	// Read address: page bits 8..0 above address bits 14..0 (32 Kbyte windows)
	wire [23:0] paged_addr = {page_next[8:0], ea_next[14:0]};       // RULE1 RULE4
	wire [23:0] base_addr  = {8'h00, ea_next};                      // RULE13
	wire        ps_read    = paged && ps_page && access_read;       // RULE1 RULE2
	wire        ps_write   = paged && ps_page && access_write;      // RULE3
	wire        read_ok    = ea_valid && access_read && !(paged && page_bad);

	// Page register with reset value
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			page_reg <= prag_pkg::PAGE_RESET;                       // RULE11
		end else begin
			page_reg <= page_next;
		end
	end

	// Registered address outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ea_reg     <= 16'h0000;
			raddr_reg  <= 24'h000000;
			rvalid_reg <= 1'b0;
		end else begin
			ea_reg     <= ea_next;
			raddr_reg  <= paged ? paged_addr : base_addr;
			rvalid_reg <= read_ok;
		end
	end

	// Registered status outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ps_reg     <= 1'b0;
			paged_reg  <= 1'b0;
			direct_reg <= 1'b0;
			wblock_reg <= 1'b0;
			trap_reg   <= 1'b0;
		end else begin
			ps_reg     <= ps_read;
			paged_reg  <= paged;
			direct_reg <= ea_valid && !in_window;                   // RULE13
			wblock_reg <= ps_write;                                 // RULE3
			trap_reg   <= paged && page_bad;                        // RULE12
		end
	end

	// Output drive
	assign read_page_register   = page_reg;
	assign effective_address    = ea_reg;
	assign read_addr            = raddr_reg;
	assign read_addr_valid      = rvalid_reg;
	assign program_space_window = ps_reg;
	assign extended_data_space  = paged_reg;
	assign base_direct          = direct_reg;
	assign ps_write_block       = wblock_reg;
	assign addr_error_trap      = trap_reg;

	// Reset loads page 0x001
	property p_reset_page;
		@(posedge clk) !reset_n |=> page_reg == 10'h001;
	endproperty
	a_reset_page: assert property (p_reset_page) else $error("page not 0x001 after reset"); // RULE11

	// Paged read address formation
	property p_addr_form;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && ea_next[15]) |=> read_addr == {$past(page_next[8:0]), $past(ea_next[14:0])};
	endproperty
	a_addr_form: assert property (p_addr_form) else $error("paged address wrong"); // RULE1

	// Program space flag tracks page bit 9
	property p_ps_map;
		@(posedge clk) disable iff (!reset_n)
		(paged && access_read && page_next >= 10'h200) |=> program_space_window;
	endproperty
	a_ps_map: assert property (p_ps_map) else $error("program space not flagged"); // RULE2

	// Writes never flagged as program space reads
	property p_no_ps_write;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && !access_read) |=> !program_space_window;
	endproperty
	a_no_ps_write: assert property (p_no_ps_write) else $error("write reached program space"); // RULE3

	// Overflow in stepping mode increments page
	property p_ovf_inc;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && stepping_mode && ea_base[15] && !ea_raw[15] && !ea_dir_down &&
		page_reg != 10'h3ff) |=> (page_reg == $past(page_reg) + 10'h001) && effective_address[15];
	endproperty
	a_ovf_inc: assert property (p_ovf_inc) else $error("overflow did not step page"); // RULE8

	// Underflow in stepping mode decrements page
	property p_unf_dec;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && stepping_mode && ea_base[15] && !ea_raw[15] && ea_dir_down &&
		page_reg != 10'h001 && page_reg != 10'h200) |=> page_reg == $past(page_reg) - 10'h001;
	endproperty
	a_unf_dec: assert property (p_unf_dec) else $error("underflow did not step page"); // RULE9

	// Wrapping modes keep page and set bit 15
	property p_wrap;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && wrap_mode && ea_base[15] && !ea_raw[15] && !page_wr) |=>
		$stable(page_reg) && effective_address[15];
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap mode changed page"); // RULE10 RULE7

	// No crossing without a paged base address
	property p_need_base;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && !ea_base[15] && !page_wr) |=> $stable(page_reg);
	endproperty
	a_need_base: assert property (p_need_base) else $error("page moved from base access"); // RULE6

	// Page zero paged access traps
	property p_trap;
		@(posedge clk) disable iff (!reset_n)
		(paged && page_next == 10'h000) |=> addr_error_trap && !read_addr_valid;
	endproperty
	a_trap: assert property (p_trap) else $error("no trap on page zero"); // RULE12

	// Boundary exceptions leave bit 15 clear
	property p_exc;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && stepping_mode && exc_case) |=> !effective_address[15] && base_direct;
	endproperty
	a_exc: assert property (p_exc) else $error("boundary exception mishandled"); // RULE14 RULE13

	// Program space flag only shows with page bit 9 set
	property p_ps_bit9;
		@(posedge clk) disable iff (!reset_n)
		program_space_window |-> read_page_register[9];
	endproperty
	a_ps_bit9: assert property (p_ps_bit9) else $error("program space without bit 9"); // RULE2

	// A paged read lies in the window of the current page
	property p_window_span;
		@(posedge clk) disable iff (!reset_n)
		(read_addr_valid && extended_data_space) |-> read_addr[23:15] == read_page_register[8:0];
	endproperty
	a_window_span: assert property (p_window_span) else $error("page window mismatch"); // RULE4

	// Base addresses pass straight through
	property p_base_addr;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && !ea_next[15]) |=> read_addr == {8'h00, $past(ea_next)} && base_direct;
	endproperty
	a_base_addr: assert property (p_base_addr) else $error("base address altered"); // RULE13

	// Writes into program space are flagged and never made valid reads
	property p_ps_write;
		@(posedge clk) disable iff (!reset_n)
		(paged && ps_page && access_write && !access_read) |=> ps_write_block && !read_addr_valid;
	endproperty
	a_ps_write: assert property (p_ps_write) else $error("program space write not refused"); // RULE3

	// Only pre- and post-modified modes move the page
	property p_step_modes;
		@(posedge clk) disable iff (!reset_n)
		(!stepping_mode && !page_wr) |=> $stable(page_reg);
	endproperty
	a_step_modes: assert property (p_step_modes) else $error("page moved in other mode"); // RULE7

	// Reads below the paged window are valid and never trap
	property p_direct_read;
		@(posedge clk) disable iff (!reset_n)
		(ea_valid && access_read && !in_window) |=> read_addr_valid && !addr_error_trap;
	endproperty
	a_direct_read: assert property (p_direct_read) else $error("direct read refused"); // RULE13

	// No request leaves the valid, paged, base and trap outputs low
	property p_idle_quiet;
		@(posedge clk) disable iff (!reset_n)
		!ea_valid |=> !read_addr_valid && !extended_data_space && !base_direct && !addr_error_trap;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("status without request"); // RULE12

	// A trap only comes from a paged access at page zero
	property p_trap_cause;
		@(posedge clk) disable iff (!reset_n)
		addr_error_trap |-> extended_data_space && read_page_register == 10'h000;
	endproperty
	a_trap_cause: assert property (p_trap_cause) else $error("trap without page zero"); // RULE12

	// A page that moved by itself always comes with bit 15 set
	property p_step_bit15;
		@(posedge clk) disable iff (!reset_n)
		(!page_wr && page_next != page_reg) |=> effective_address[15] && extended_data_space;
	endproperty
	a_step_bit15: assert property (p_step_bit15) else $error("step without bit 15"); // RULE8 RULE9

	// Main scenarios
	c_ovf:  cover property (@(posedge clk) disable iff (!reset_n) do_step && is_ovf);
	c_unf:  cover property (@(posedge clk) disable iff (!reset_n) do_step && is_unf);
	c_wrap: cover property (@(posedge clk) disable iff (!reset_n) do_wrap);
	c_trap: cover property (@(posedge clk) disable iff (!reset_n) addr_error_trap);
	c_psw:  cover property (@(posedge clk) disable iff (!reset_n) ps_write_block);
endmodule : prag_gen

// *** verif/prag_cpu_model.sv ***
// CPU effective address model feeding the paged read address generator
module prag_cpu_model (
	input  wire logic [15:0]             base, // Pointer before modification
	input  wire logic [15:0]             step, // Signed modifier
	input  wire prag_pkg::prag_mode_type mode, // Addressing mode
	output logic      [15:0]             raw,  // Raw modified address
	output logic                         down  // Modifier is negative
);
	timeunit 1ns;
	timeprecision 1ns;
	// Plain indirect leaves the pointer alone; a crossing drops bit 15 by plain wrap
	assign raw  = (mode == prag_pkg::PRAG_MODE_INDIRECT) ? base : base + step;
	// Direction follows the sign of the modifier
	assign down = step[15];
endmodule : prag_cpu_model

// *** verif/paged_read_address_gen_test.sv ***
// Self-checking bench for the paged read address generator
module paged_read_address_gen_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    clk, reset_n, ea_valid, ea_dir_down; // Clock, reset, request
	logic                    access_read, access_write, page_wr;  // Access kind, page load
	logic [9:0]              page_wdata, rpg, exp_pg;             // Page in, out, expected
	logic [15:0]             ea_base, step, ea_raw, ea, b, s;     // Addresses
	prag_pkg::prag_mode_type ea_mode;                             // Addressing mode
	logic [23:0]             raddr;                               // Extended read address
	logic                    rav, psw, pgd, bdir, psb, trap;      // Result flags
	int                      num_errors, n_checks, seed;          // Counters and seed

	// Far side: effective address calculation
	prag_cpu_model CPU (.base(ea_base), .step(step), .mode(ea_mode), .raw(ea_raw),
		.down(ea_dir_down));

	prag_gen DUT (.clk(clk), .reset_n(reset_n), .ea_valid(ea_valid), .ea_base(ea_base),
		.ea_raw(ea_raw), .ea_dir_down(ea_dir_down), .ea_mode(ea_mode),
		.access_read(access_read), .access_write(access_write), .page_wr(page_wr),
		.page_wdata(page_wdata), .read_page_register(rpg), .effective_address(ea),
		.read_addr(raddr), .read_addr_valid(rav), .program_space_window(psw),
		.extended_data_space(pgd), .base_direct(bdir), .ps_write_block(psb),
		.addr_error_trap(trap));

	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Idle cycle, optionally loading the page register
	task automatic idle(input logic pw, input logic [9:0] pv);
		ea_valid = 1'b0;
		page_wr = pw;
		page_wdata = pv;
		if (pw)
			exp_pg = pv;
		@(posedge clk);
		#1;
		chk(rpg, exp_pg);
	endtask : idle

	// Expected page and corrected address after one request
	function automatic logic [25:0] expect_step(input logic [15:0] bb, input logic [15:0] ss,
		input prag_pkg::prag_mode_type m, input logic [9:0] pg);
		logic        x, pm;
		logic [9:0]  p;
		logic [15:0] e;
		p = pg;
		e = (m == prag_pkg::PRAG_MODE_INDIRECT) ? bb : bb + ss;
		x = bb[15] & !e[15];
		pm = (m == prag_pkg::PRAG_MODE_PRE_MOD) || (m == prag_pkg::PRAG_MODE_POST_MOD);
		if (x && !pm)
			e[15] = 1'b1;
		else if (x && !ss[15] && p != 10'h3ff) begin
			p = p + 10'h001;
			e[15] = 1'b1;
		end else if (x && ss[15] && p != 10'h001 && p != 10'h200) begin
			p = p - 10'h001;
			e[15] = 1'b1;
		end
		return {p, e};
	endfunction : expect_step

	// One request, expectation from the function above, checked one cycle later
	task automatic op(input logic [15:0] bb, input logic [15:0] ss,
		input prag_pkg::prag_mode_type m, input logic w);
		logic        tr;
		logic [9:0]  p;
		logic [15:0] e;
		logic [5:0]  fl;
		ea_valid = 1'b1;
		page_wr = 1'b0;
		ea_base = bb;
		step = ss;
		ea_mode = m;
		access_write = w;
		access_read = !w;
		{p, e} = expect_step(bb, ss, m, exp_pg);
		exp_pg = p;
		tr = e[15] && p == 10'h000;
		fl = {!w && !tr, e[15] && !w && p[9], e[15], !e[15], e[15] && w && p[9], tr};
		@(posedge clk);
		#1;
		chk(rpg, p);
		chk(ea, e);
		chk({rav, psw, pgd, bdir, psb, trap}, fl);
		if (!w && !tr)
			chk(raddr, e[15] ? {p[8:0], e[14:0]} : {8'h00, e});
	endtask : op

	// Counts, verdict and end of run
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// Watchdog well beyond the expected run
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	// Main sequence: corner cases, then random traffic
	initial begin
		{ea_valid, access_read, access_write, page_wr} = 4'h0;
		{page_wdata, ea_base, step} = '0;
		ea_mode = prag_pkg::PRAG_MODE_INDIRECT;
		num_errors = 0;
		n_checks = 0;
		seed = 32'h6750dcb9;
		exp_pg = 10'h001;
		reset_n = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		reset_n = 1'b1;
		idle(1'b0, 10'h000);
		idle(1'b1, 10'h2ff);
		op(16'hfffe, 16'h0002, prag_pkg::PRAG_MODE_PRE_MOD, 1'b0);
		op(16'h8000, 16'hfffe, prag_pkg::PRAG_MODE_POST_MOD, 1'b0);
		idle(1'b1, 10'h3ff);
		op(16'hfffe, 16'h0002, prag_pkg::PRAG_MODE_POST_MOD, 1'b0);
		idle(1'b1, 10'h001);
		op(16'h8000, 16'hfffe, prag_pkg::PRAG_MODE_PRE_MOD, 1'b0);
		idle(1'b1, 10'h200);
		op(16'h8000, 16'hfffe, prag_pkg::PRAG_MODE_POST_MOD, 1'b1);
		op(16'h7ffe, 16'h0004, prag_pkg::PRAG_MODE_PRE_MOD, 1'b1);
		for (int i = 3; i < 6; i++) begin
			op(16'hfffe, 16'h0002, prag_pkg::prag_mode_type'(i), 1'b0);
			op(16'h8000, 16'hfffe, prag_pkg::prag_mode_type'(i), 1'b0);
		end
		idle(1'b1, 10'h000);
		op(16'h9000, 16'h0000, prag_pkg::PRAG_MODE_INDIRECT, 1'b0);
		op(16'h1000, 16'h0000, prag_pkg::PRAG_MODE_INDIRECT, 1'b0);
		// Second reset in mid-run
		reset_n = 1'b0;
		exp_pg = 10'h001;
		@(posedge clk);
		#1;
		reset_n = 1'b1;
		idle(1'b0, 10'h000);
		for (int n = 0; n < 400; n++) begin
			b = $random(seed);
			s = $random(seed);
			if (b[0])
				b[14:1] = {14{b[1]}};
			if (s[8:7] == 2'b00)
				idle(1'b1, 10'(({$random(seed)} % 1023) + 1));
			else
				op(b, {{12{s[3]}}, s[3:1], 1'b0},
					prag_pkg::prag_mode_type'({$random(seed)} % 6), s[9]);
		end
		idle(1'b0, 10'h000);
		report_and_stop();
	end
endmodule : paged_read_address_gen_test
